// File: verilog/adcph_pkg.sv
// package: constants and types for the parallel host port of the converter
package adcph_pkg;
   // data bus and result widths
   localparam int unsigned RESULT_W   = 10;
   localparam int unsigned BUS_W      = 8;
   localparam int unsigned HI_W       = 2;
   // control byte field position of the acquisition mode select
   localparam int unsigned ACQ_MODE_BIT = 5;
   // clock cycles of conversion and of internally timed acquisition
   localparam int unsigned CONV_CYCLES = 13;
   localparam int unsigned ACQ_CYCLES  = 3;
   localparam int unsigned CNT_W       = 4;
   // on-chip oscillator: period in ns, derived divide from the 20 ns system clock
   localparam int unsigned SYS_PERIOD_NS = 20;
   localparam int unsigned OSC_PERIOD_NS = 240;
   localparam int unsigned OSC_DIV       = OSC_PERIOD_NS / SYS_PERIOD_NS;
   localparam int unsigned DIV_W         = 8;
   // reset values
   localparam logic [BUS_W-1:0]    CFG_RESET    = 8'h00;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

   // sequencer states
   typedef enum logic [1:0] {
      ADCPH_IDLE     = 2'b00,
      ADCPH_ACQ_INT  = 2'b01,
      ADCPH_ACQ_EXT  = 2'b10,
      ADCPH_CONVERT  = 2'b11
   } adcph_state_t;
endpackage : adcph_pkg

// File: verilog/adcph_host_port.sv
// module: byte-wide host port, conversion sequencer and done flag of the converter
// Overview of operation
// RULE1: the 10-bit result reads as two bytes: top two bits at select 1, low eight at 0.
// RULE2: the two lowest data lines carry bits 1:0 with select low and bits 9:8 with select high.
// RULE3: the done flag output goes low when a conversion ends and the result is ready.
// RULE4: a read strobe fall with chip select low drives the selected byte onto the bus.
// RULE5: in internal acquisition a write rise stores the byte and runs acquisition, conversion.
// RULE6: in external acquisition the next write rise ends acquisition, starts conversion.
// RULE7: in external clock mode the host supplies a continuous clock on the clock pin; the bench host model pulses it only inside its tick task.
// RULE8: in internal clock mode the block runs from its own oscillator, ignoring the pin.
// RULE9: with chip select high all eight data lines are released.
// RULE10: the done flag returns high on the first read or on a new control byte write.
// RULE11: every conversion lasts 13 clock cycles in any clock or acquisition mode.
// RULE12: a control byte written during a conversion aborts it and starts a fresh acquisition.
// RULE13: the host writes with the mode bit at 1 to start acquiring, then with it at 0 to convert.
// RULE14: strobe edges while chip select is high are ignored entirely.
`timescale 1ns/1ps
`default_nettype none
module adcph_host_port
   import adcph_pkg::*;
#(
   parameter int unsigned CONV_LEN = CONV_CYCLES,
   parameter int unsigned ACQ_LEN  = ACQ_CYCLES
) (
   // clock and reset
   input  wire  logic                mclk_in,
   input  wire  logic                reset_n_in,
   // host strobes (asynchronous pins)
   input  wire  logic                chip_sel_n_in,
   input  wire  logic                rd_n_in,
   input  wire  logic                wr_n_in,
   input  wire  logic                high_byte_select_in,
   input  wire  logic                conv_clk_in,
   input  wire  logic                int_clk_mode_in,
   // data bus, three signals per line
   input  wire  logic [BUS_W-1:0]    data_in,
   output logic       [BUS_W-1:0]    data_out,
   output logic       [BUS_W-1:0]    data_oe_n_out,
   // conversion core
   input  wire  logic [RESULT_W-1:0] sample_in,
   output logic       [BUS_W-1:0]    config_out,
   output logic                      tracking_out,
   // done flag, active low
   output logic                      conv_done_n_out
);

   // two-stage synchronisers for every host pin; reset and the sample bus are not synchronised
   logic [6+BUS_W-1:0] sync1_ff;
   logic [6+BUS_W-1:0] sync2_ff;
   always_ff @(posedge mclk_in) begin
      sync1_ff <= {chip_sel_n_in, rd_n_in, wr_n_in, high_byte_select_in,
                   conv_clk_in, int_clk_mode_in, data_in};
      sync2_ff <= sync1_ff;
   end
   logic             cs_n_s, rd_n_s, wr_n_s, hbs_s, cclk_s, intclk_s;
   logic [BUS_W-1:0] data_s;
   assign {cs_n_s, rd_n_s, wr_n_s, hbs_s, cclk_s, intclk_s, data_s} = sync2_ff;

   // edge detect history on synchronised strobes
   logic rd_n_d_ff, wr_n_d_ff, cclk_d_ff;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         rd_n_d_ff <= 1'b1;
         wr_n_d_ff <= 1'b1;
         cclk_d_ff <= 1'b0;
      end else begin
         rd_n_d_ff <= rd_n_s;
         wr_n_d_ff <= wr_n_s;
         cclk_d_ff <= cclk_s;
      end
   end
   logic rd_fall, wr_rise;
   assign rd_fall = !cs_n_s && rd_n_d_ff && !rd_n_s;  // RULE4 RULE14
   assign wr_rise = !cs_n_s && !wr_n_d_ff && wr_n_s;  // RULE14

   // on-chip oscillator as an enable pulse from a divider
   logic [DIV_W-1:0] div_ff;
   logic             osc_tick;
   assign osc_tick = (div_ff == DIV_W'(OSC_DIV - 1));
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) div_ff <= '0;
      else if (osc_tick) div_ff <= '0;
      else div_ff <= div_ff + DIV_W'(1);
   end

   // conversion clock tick: falling edge of pin clock or oscillator tick
   logic conv_tick;
   assign conv_tick = intclk_s ? osc_tick : (cclk_d_ff && !cclk_s);  // RULE8 RULE7

   // control byte store
   logic [BUS_W-1:0] config_ff;
   logic             acq_ext_req;
   assign acq_ext_req = data_s[ACQ_MODE_BIT];
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) config_ff <= CFG_RESET;
      else if (wr_rise) config_ff <= data_s;  // RULE5
   end
   assign config_out = config_ff;

   // sequencer
   adcph_state_t      state_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic              conv_end;
   assign conv_end = (state_ff == ADCPH_CONVERT) && conv_tick
                     && (cnt_ff == CNT_W'(CONV_LEN - 1));
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         state_ff <= ADCPH_IDLE;
         cnt_ff   <= '0;
      end else if (wr_rise) begin
         cnt_ff <= '0;
         unique case (state_ff)
            ADCPH_ACQ_EXT:
               state_ff <= acq_ext_req ? ADCPH_ACQ_EXT : ADCPH_CONVERT;  // RULE6 RULE13
            default:
               state_ff <= acq_ext_req ? ADCPH_ACQ_EXT : ADCPH_ACQ_INT;  // RULE5 RULE12
         endcase
      end else if (conv_tick) begin
         unique case (state_ff)
            ADCPH_IDLE, ADCPH_ACQ_EXT: cnt_ff <= '0;
            ADCPH_ACQ_INT: begin
               if (cnt_ff == CNT_W'(ACQ_LEN - 1)) begin
                  state_ff <= ADCPH_CONVERT;
                  cnt_ff   <= '0;
               end else cnt_ff <= cnt_ff + CNT_W'(1);
            end
            ADCPH_CONVERT: begin
               if (conv_end) begin  // RULE11
                  state_ff <= ADCPH_IDLE;
                  cnt_ff   <= '0;
               end else cnt_ff <= cnt_ff + CNT_W'(1);
            end
         endcase
      end
   end

   // track/hold indication
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) tracking_out <= 1'b0;
      else tracking_out <= (state_ff == ADCPH_ACQ_INT) || (state_ff == ADCPH_ACQ_EXT);
   end

   // result latch at end of conversion
   logic [RESULT_W-1:0] result_ff;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) result_ff <= RESULT_RESET;
      else if (conv_end && !wr_rise) result_ff <= sample_in;
   end

   // done flag: set wins over a read in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) conv_done_n_out <= 1'b1;
      else if (wr_rise) conv_done_n_out <= 1'b1;  // RULE10
      else if (conv_end) conv_done_n_out <= 1'b0;  // RULE3
      else if (rd_fall) conv_done_n_out <= 1'b1;  // RULE10
   end

   // byte select function
   function automatic logic [BUS_W-1:0] pick_byte(input logic [RESULT_W-1:0] r,
                                                  input logic hi);
      pick_byte = hi ? {{(BUS_W-HI_W){1'b0}}, r[RESULT_W-1 -: HI_W]}
                     : r[BUS_W-1:0];  // RULE1 RULE2
   endfunction : pick_byte

   // bus drive: enabled from read fall until read rise or chip select rise
   logic drive_ff;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) drive_ff <= 1'b0;
      else if (cs_n_s || rd_n_s) drive_ff <= 1'b0;  // RULE9 RULE14
      else if (rd_fall) drive_ff <= 1'b1;  // RULE4
   end
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         data_out      <= '0;
         data_oe_n_out <= '1;
      end else begin
         data_out      <= pick_byte(result_ff, hbs_s);
         data_oe_n_out <= {BUS_W{!(drive_ff && !cs_n_s && !rd_n_s)}};  // RULE9
      end
   end

   // checks
   a_bus_release_cs: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      cs_n_s |=> data_oe_n_out == '1)  // RULE9
      else $error("data bus driven while chip select high");
   a_read_drives_bus: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      rd_fall ##1 (!cs_n_s && !rd_n_s) |=> data_oe_n_out == '0)  // RULE4
      else $error("read did not drive bus");
   a_byte_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      hbs_s |=> data_out[BUS_W-1:HI_W] == '0)  // RULE1
      else $error("upper byte has nonzero high lines");
   a_low_lines_map: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      1'b1 |=> data_out[HI_W-1:0] == ($past(hbs_s) ? $past(result_ff[RESULT_W-1 -: HI_W])
                                                   : $past(result_ff[HI_W-1:0])))  // RULE2
      else $error("low data lines wrong");
   a_done_low_end: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      conv_end && !wr_rise |=> !conv_done_n_out)  // RULE3
      else $error("done flag not set at end");
   a_done_clear: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (wr_rise || (rd_fall && !conv_end)) |=> conv_done_n_out)  // RULE10
      else $error("done flag not released");
   a_write_stores: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      wr_rise |=> config_out == $past(data_s))  // RULE5
      else $error("control byte not stored");
   a_abort_conv: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (wr_rise && !acq_ext_req && state_ff == ADCPH_CONVERT)
      |=> state_ff == ADCPH_ACQ_INT)  // RULE12
      else $error("write did not abort conversion");
   a_ext_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (wr_rise && !acq_ext_req && state_ff == ADCPH_ACQ_EXT)
      |=> state_ff == ADCPH_CONVERT)  // RULE6
      else $error("external acquisition did not convert");
   // conversion ticks counted apart from the sequencer, for the length checks
   logic [CNT_W-1:0] chk_ticks_ff;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in || (state_ff != ADCPH_CONVERT)) chk_ticks_ff <= '0;
      else if (conv_tick && !wr_rise) chk_ticks_ff <= chk_ticks_ff + CNT_W'(1);
   end
   a_conv_length: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      conv_end |-> chk_ticks_ff == CNT_W'(CONV_LEN - 1))  // RULE11
      else $error("conversion length wrong");
   a_conv_bound: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (state_ff == ADCPH_CONVERT) |-> chk_ticks_ff < CNT_W'(CONV_LEN))  // RULE11
      else $error("conversion ran past its length");
   a_ignore_cs_high: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      cs_n_s |=> $stable(config_out))  // RULE14
      else $error("write taken with chip select high");
   c_internal_conv: cover property (@(posedge mclk_in)
      state_ff == ADCPH_ACQ_INT ##[1:300] conv_end);
   c_external_conv: cover property (@(posedge mclk_in)
      state_ff == ADCPH_ACQ_EXT ##[1:300] conv_end);
   c_read_after_done: cover property (@(posedge mclk_in) !conv_done_n_out ##[1:50] rd_fall);
   c_abort: cover property (@(posedge mclk_in) state_ff == ADCPH_CONVERT && wr_rise);
endmodule : adcph_host_port
`default_nettype wire

// File: sim/adcph_host_model.sv
// host processor model driving strobes and the shared data bus
`timescale 1ns/1ps
`default_nettype none
module adcph_host_model
   import adcph_pkg::*;
(
   // clock
   input  wire logic             mclk_in,
   // bus as driven by the device
   input  wire logic [BUS_W-1:0] data_out_in,
   input  wire logic [BUS_W-1:0] data_oe_n_in,
   // strobes and resolved bus toward the device
   output logic                  chip_sel_n_out,
   output logic                  rd_n_out,
   output logic                  wr_n_out,
   output logic                  high_byte_select_out,
   output logic                  conv_clk_out,
   output logic [BUS_W-1:0]      data_to_dev_out
);
   logic [BUS_W-1:0] idle_ff;
   logic [BUS_W-1:0] wdata;
   logic             hold;
   initial begin
      chip_sel_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      high_byte_select_out = 1'b0;
      conv_clk_out = 1'b0;
      idle_ff = 8'h00;
      wdata = 8'h00;
      hold = 1'b0;
   end
   // released bus toggles every cycle so stale values never pass
   always @(posedge mclk_in) idle_ff <= ~idle_ff;
   // wire level: device bits where enabled, else host byte or idle pattern
   assign data_to_dev_out = (~data_oe_n_in & data_out_in)
                          | (data_oe_n_in & (hold ? wdata : idle_ff));
   // one write cycle, byte held over the whole strobe
   task automatic wr_byte(input logic [BUS_W-1:0] b, input logic cs_n);
      @(posedge mclk_in);
      chip_sel_n_out <= cs_n;
      hold <= 1'b1;
      wdata <= b;
      wr_n_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
      wr_n_out <= 1'b1;
      repeat (5) @(posedge mclk_in);
      chip_sel_n_out <= 1'b1;
      hold <= 1'b0;
   endtask : wr_byte
   // one read cycle, bus sampled while the strobe is still low
   task automatic rd_byte(input logic hbs, input logic cs_n,
                          output logic [BUS_W-1:0] d, output logic [BUS_W-1:0] oe);
      @(posedge mclk_in);
      chip_sel_n_out <= cs_n;
      high_byte_select_out <= hbs;
      rd_n_out <= 1'b0;
      repeat (7) @(posedge mclk_in);
      d = data_to_dev_out;
      oe = data_oe_n_in;
      rd_n_out <= 1'b1;
      chip_sel_n_out <= 1'b1;
      repeat (4) @(posedge mclk_in);
   endtask : rd_byte
   // conversion clock pulses, still between frames
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         conv_clk_out <= 1'b1;
         repeat (3) @(posedge mclk_in);
         conv_clk_out <= 1'b0;
         repeat (3) @(posedge mclk_in);
      end
   endtask : tick
endmodule : adcph_host_model
`default_nettype wire

// File: sim/test_adcph_host_port.sv
// self-checking bench for the converter host port
`timescale 1ns/1ps
`default_nettype none
module test_adcph_host_port
   import adcph_pkg::*;
;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic int_clk_mode_in = 1'b0;
   logic [RESULT_W-1:0] sample_in = 10'h2A5;
   wire logic cs_n, rd_n, wr_n, hbs, cclk, trk, done_n;
   wire logic [BUS_W-1:0] din, dout, oe_n, cfg;
   logic [BUS_W-1:0] d, oe;
   int mismatches = 0;
   int checked = 0;
   // 50 MHz clock
   always #10 mclk_in = ~mclk_in;
   adcph_host_model host (.mclk_in(mclk_in), .data_out_in(dout), .data_oe_n_in(oe_n),
      .chip_sel_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .high_byte_select_out(hbs), .conv_clk_out(cclk), .data_to_dev_out(din));
   adcph_host_port dut (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .chip_sel_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
      .high_byte_select_in(hbs), .conv_clk_in(cclk), .int_clk_mode_in(int_clk_mode_in),
      .data_in(din), .data_out(dout), .data_oe_n_out(oe_n), .sample_in(sample_in),
      .config_out(cfg), .tracking_out(trk), .conv_done_n_out(done_n));
   task automatic close_out();
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [BUS_W-1:0] seen,
                        input logic [BUS_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // bounded wait for the done flag to fall
   task automatic wait_done(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_in);
         if (done_n === 1'b0) return;
      end
      mismatches++;
      close_out();
   endtask : wait_done
   // strobes with chip select high do nothing
   task automatic sc_refuse();
      host.wr_byte(8'h5A, 1'b1);
      check("config", cfg, 8'h00);
      host.rd_byte(1'b0, 1'b1, d, oe);
      check("enables", oe, 8'hFF);
   endtask : sc_refuse
   // external acquisition, external clock, then both result bytes
   task automatic sc_ext_acq();
      host.wr_byte(8'h20, 1'b0);
      check("tracking", BUS_W'(trk), 8'h01);
      host.wr_byte(8'h00, 1'b0);
      check("config", cfg, 8'h00);
      check("tracking", BUS_W'(trk), 8'h00);
      host.tick(12);
      check("done early", BUS_W'(done_n), 8'h01);
      host.tick(1);
      repeat (4) @(posedge mclk_in);
      check("done", BUS_W'(done_n), 8'h00);
      host.rd_byte(1'b1, 1'b0, d, oe);
      check("high byte", d, 8'h02);
      check("enables", oe, 8'h00);
      check("done after read", BUS_W'(done_n), 8'h01);
      host.rd_byte(1'b0, 1'b0, d, oe);
      check("low byte", d, 8'hA5);
   endtask : sc_ext_acq
   // write mid-conversion restarts acquisition and timing
   task automatic sc_abort();
      sample_in <= 10'h15A;
      host.wr_byte(8'h00, 1'b0);
      host.tick(8);
      host.wr_byte(8'h01, 1'b0);
      check("config", cfg, 8'h01);
      check("tracking", BUS_W'(trk), 8'h01);
      host.tick(15);
      check("done early", BUS_W'(done_n), 8'h01);
      host.tick(1);
      repeat (4) @(posedge mclk_in);
      check("done", BUS_W'(done_n), 8'h00);
      host.wr_byte(8'h00, 1'b0);
      check("done after write", BUS_W'(done_n), 8'h01);
      host.rd_byte(1'b1, 1'b0, d, oe);
      check("high byte", d, 8'h01);
      host.rd_byte(1'b0, 1'b0, d, oe);
      check("low byte", d, 8'h5A);
   endtask : sc_abort
   // on-chip oscillator with the clock pin static
   task automatic sc_int_clk();
      @(posedge mclk_in);
      int_clk_mode_in <= 1'b1;
      sample_in <= 10'h3C3;
      host.wr_byte(8'h00, 1'b0);
      repeat (150) @(posedge mclk_in);
      check("done early", BUS_W'(done_n), 8'h01);
      wait_done(300);
      check("done", BUS_W'(done_n), 8'h00);
      host.rd_byte(1'b0, 1'b0, d, oe);
      check("low byte", d, 8'hC3);
      check("done after read", BUS_W'(done_n), 8'h01);
   endtask : sc_int_clk
   // main sequence
   initial begin
      repeat (20) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      sc_refuse();
      sc_ext_acq();
      sc_abort();
      sc_int_clk();
      close_out();
   end
   // overall hang guard
   initial begin
      repeat (50000) @(posedge mclk_in);
      mismatches++;
      close_out();
   end
endmodule : test_adcph_host_port
`default_nettype wire
